//--- design/sp_regs.sv
// module: stack top pointer and indirect pointer register file
//
// Contract
// RULE_01: stack grows downward; storing moves the top pointer lower.
// RULE_02: the top pointer always holds the current stack top location.
// RULE_03: single-byte push lowers the top pointer by one.
// RULE_04: call or interrupt entry lowers the top pointer by two.
// RULE_05: single-byte pop raises the top pointer by one.
// RULE_06: subroutine or interrupt return raises the top pointer by two.
// RULE_07: top pointer split into high and low 8-bit read/write bytes.
// RULE_08: small data spaces keep only the low byte; high byte absent.
// RULE_09: software loads the top pointer above 0x0100 before calls.
// RULE_10: registers 26 to 31 pair into three 16-bit pointers.
// RULE_11: pointers support displacement, post-increment and pre-decrement.
// RULE_12: reset loads both bytes from the highest sram address.
// RULE_13: lower-numbered register is low byte, higher-numbered is high.
module sp_regs (
   input  wire logic                 clock,
   input  wire logic                 arst_n,
   input  wire logic                 ce,
   input  wire sp_pkg::sp_op_type    stack_op,
   input  wire logic                 sp_lo_wr,
   input  wire logic                 sp_hi_wr,
   input  wire logic [7:0]           sp_wr_data,
   input  wire logic                 gpr_wr,
   input  wire logic [4:0]           gpr_wr_idx,
   input  wire logic [7:0]           gpr_wr_data,
   input  wire logic [2:0]           ptr_use,
   input  wire sp_pkg::sp_pmode_type ptr_mode,
   input  wire logic [5:0]           ptr_disp,
   output logic [7:0]                stack_pointer_low_ff,
   output logic [7:0]                stack_pointer_high_ff,
   output logic [15:0]               stack_addr_ff,
   output logic [15:0]               ptr_addr_ff,
   output logic [15:0]               ptr_x_ff,
   output logic [15:0]               ptr_y_ff,
   output logic [15:0]               ptr_z_ff
);
   logic [15:0] sp_cur;
   logic [15:0] nxt_sp;
   logic [15:0] nxt_stack_addr;
   logic [15:0] nxt_ptr_addr;
   logic [15:0] addr_x;
   logic [15:0] addr_y;
   logic [15:0] addr_z;
   logic [2:0]  wr_lo;
   logic [2:0]  wr_hi;

   // --------------------------------------------------------------
   // stack top pointer
   // --------------------------------------------------------------
   // one word view keeps the step arithmetic in one adder
   assign sp_cur = {stack_pointer_high_ff, stack_pointer_low_ff}; // see RULE_07

   always_comb begin
      nxt_sp         = sp_cur;
      nxt_stack_addr = sp_cur; // see RULE_02
      unique case (stack_op)
         sp_pkg::SP_OP_NONE: begin
            nxt_sp = sp_cur;
         end
         sp_pkg::SP_OP_PUSH: begin
            nxt_sp = sp_cur - sp_pkg::STEP_BYTE; // see RULE_01 see RULE_03
         end
         sp_pkg::SP_OP_CALL: begin
            nxt_sp = sp_cur - sp_pkg::STEP_ADDR; // see RULE_04
         end
         sp_pkg::SP_OP_POP: begin
            nxt_sp         = sp_cur + sp_pkg::STEP_BYTE; // see RULE_05
            nxt_stack_addr = nxt_sp;
         end
         sp_pkg::SP_OP_RET: begin
            nxt_sp         = sp_cur + sp_pkg::STEP_ADDR; // see RULE_06
            nxt_stack_addr = sp_cur + sp_pkg::STEP_BYTE;
         end
         default: begin
            nxt_sp = sp_cur; // illegal op codes leave the pointer alone
         end
      endcase
      // software writes win; the core never mixes both in one cycle
      if (sp_lo_wr) begin
         nxt_sp[7:0] = sp_wr_data; // see RULE_07
      end
      if (sp_hi_wr && sp_pkg::HAS_HIGH_BYTE) begin
         nxt_sp[15:8] = sp_wr_data; // see RULE_07
      end
      if (!sp_pkg::HAS_HIGH_BYTE) begin
         nxt_sp[15:8] = sp_pkg::BYTE_ZERO; // see RULE_08
      end
   end

   // --------------------------------------------------------------
   // low byte register
   // --------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stack_pointer_low_ff <= sp_pkg::SRAM_TOP[7:0]; // see RULE_12
      end else if (ce) begin
         stack_pointer_low_ff <= nxt_sp[7:0]; // see RULE_07
      end
   end

   // --------------------------------------------------------------
   // high byte register, absent for small data spaces
   // --------------------------------------------------------------
   generate
      if (sp_pkg::HAS_HIGH_BYTE) begin : g_high
         always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
               stack_pointer_high_ff <= sp_pkg::SRAM_TOP[15:8]; // see RULE_12
            end else if (ce) begin
               stack_pointer_high_ff <= nxt_sp[15:8]; // see RULE_07
            end
         end
      end else begin : g_no_high
         // reads as zero; writes to it are dropped
         assign stack_pointer_high_ff = sp_pkg::BYTE_ZERO; // see RULE_08
      end
   endgenerate

   // --------------------------------------------------------------
   // stack access address
   // --------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stack_addr_ff <= sp_pkg::SRAM_TOP;
      end else if (ce) begin
         stack_addr_ff <= nxt_stack_addr; // see RULE_02
      end
   end

   // --------------------------------------------------------------
   // indirect pointers, decoded from general register writes
   // --------------------------------------------------------------
   always_comb begin
      wr_lo    = 3'h0;
      wr_hi    = 3'h0;
      wr_lo[0] = gpr_wr && (gpr_wr_idx == sp_pkg::REG_X_LO); // see RULE_10
      wr_hi[0] = gpr_wr && (gpr_wr_idx == sp_pkg::REG_X_HI);
      wr_lo[1] = gpr_wr && (gpr_wr_idx == sp_pkg::REG_Y_LO);
      wr_hi[1] = gpr_wr && (gpr_wr_idx == sp_pkg::REG_Y_HI);
      wr_lo[2] = gpr_wr && (gpr_wr_idx == sp_pkg::REG_Z_LO);
      wr_hi[2] = gpr_wr && (gpr_wr_idx == sp_pkg::REG_Z_HI);
   end

   // --------------------------------------------------------------
   // x pointer, registers 26 and 27
   // --------------------------------------------------------------
   sp_ptr_pair u_ptr_x (
      .clock   (clock),
      .arst_n  (arst_n),
      .ce      (ce),
      .wr_lo   (wr_lo[0]),
      .wr_hi   (wr_hi[0]),
      .wr_data (gpr_wr_data),
      .use_en  (ptr_use[0]),
      .mode    (ptr_mode),
      .disp    (ptr_disp),
      .ptr_ff  (ptr_x_ff),
      .addr    (addr_x)
   );

   // --------------------------------------------------------------
   // y pointer, registers 28 and 29
   // --------------------------------------------------------------
   sp_ptr_pair u_ptr_y (
      .clock   (clock),
      .arst_n  (arst_n),
      .ce      (ce),
      .wr_lo   (wr_lo[1]),
      .wr_hi   (wr_hi[1]),
      .wr_data (gpr_wr_data),
      .use_en  (ptr_use[1]),
      .mode    (ptr_mode),
      .disp    (ptr_disp),
      .ptr_ff  (ptr_y_ff),
      .addr    (addr_y)
   );

   // --------------------------------------------------------------
   // z pointer, registers 30 and 31
   // --------------------------------------------------------------
   sp_ptr_pair u_ptr_z (
      .clock   (clock),
      .arst_n  (arst_n),
      .ce      (ce),
      .wr_lo   (wr_lo[2]),
      .wr_hi   (wr_hi[2]),
      .wr_data (gpr_wr_data),
      .use_en  (ptr_use[2]),
      .mode    (ptr_mode),
      .disp    (ptr_disp),
      .ptr_ff  (ptr_z_ff),
      .addr    (addr_z)
   );

   // --------------------------------------------------------------
   // registered data address of the pointer in use
   // --------------------------------------------------------------
   always_comb begin
      nxt_ptr_addr = ptr_addr_ff;
      // lowest pointer wins should the core ever raise two uses
      if (ptr_use[0]) begin
         nxt_ptr_addr = addr_x;
      end else if (ptr_use[1]) begin
         nxt_ptr_addr = addr_y;
      end else if (ptr_use[2]) begin
         nxt_ptr_addr = addr_z;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ptr_addr_ff <= sp_pkg::WORD_ZERO;
      end else if (ce) begin
         ptr_addr_ff <= nxt_ptr_addr;
      end
   end
endmodule // sp_regs

//--- design/sp_pkg.sv
// package: constants and types of the stack and pointer register block
package sp_pkg;
   localparam int          DATA_W          = 8;
   localparam int          ADDR_W          = 16;
   localparam int          REGF_W          = 5;
   // highest sram address; plain default, set per implementation
   localparam logic [15:0] SRAM_TOP        = 16'h04ff;
   localparam bit          HAS_HIGH_BYTE   = 1'b1;
   localparam logic [15:0] STEP_BYTE       = 16'h0001;
   localparam logic [15:0] STEP_ADDR       = 16'h0002;
   localparam logic [4:0]  REG_X_LO        = 5'h1a;
   localparam logic [4:0]  REG_X_HI        = 5'h1b;
   localparam logic [4:0]  REG_Y_LO        = 5'h1c;
   localparam logic [4:0]  REG_Y_HI        = 5'h1d;
   localparam logic [4:0]  REG_Z_LO        = 5'h1e;
   localparam logic [4:0]  REG_Z_HI        = 5'h1f;
   localparam logic [7:0]  BYTE_ZERO       = 8'h00;
   localparam logic [15:0] WORD_ZERO       = 16'h0000;

   // stack operation codes, one-hot
   typedef enum logic [4:0] {
      SP_OP_NONE  = 5'h01,
      SP_OP_PUSH  = 5'h02,
      SP_OP_CALL  = 5'h04,
      SP_OP_POP   = 5'h08,
      SP_OP_RET   = 5'h10
   } sp_op_type;

   // indirect pointer addressing modes, one-hot
   typedef enum logic [2:0] {
      SP_PM_DISP  = 3'h1,
      SP_PM_POST  = 3'h2,
      SP_PM_PRE   = 3'h4
   } sp_pmode_type;
endpackage : sp_pkg

//--- design/sp_ptr_pair.sv
// module: one 16-bit indirect pointer built from two general registers
module sp_ptr_pair (
   input  wire logic                clock,
   input  wire logic                arst_n,
   input  wire logic                ce,
   input  wire logic                wr_lo,
   input  wire logic                wr_hi,
   input  wire logic [7:0]          wr_data,
   input  wire logic                use_en,
   input  wire sp_pkg::sp_pmode_type mode,
   input  wire logic [5:0]          disp,
   output logic [15:0]              ptr_ff,
   output logic [15:0]              addr
);
   logic [15:0] nxt_ptr;

   // --------------------------------------------------------------
   // address and update
   // --------------------------------------------------------------
   always_comb begin
      nxt_ptr = ptr_ff;
      addr    = ptr_ff;
      if (use_en) begin
         unique case (mode)
            sp_pkg::SP_PM_DISP: begin
               addr = ptr_ff + {10'h000, disp}; // see RULE_11
            end
            sp_pkg::SP_PM_POST: begin
               nxt_ptr = ptr_ff + sp_pkg::STEP_BYTE; // see RULE_11
            end
            sp_pkg::SP_PM_PRE: begin
               nxt_ptr = ptr_ff - sp_pkg::STEP_BYTE; // see RULE_11
               addr    = nxt_ptr;
            end
            default: begin
               addr = ptr_ff;
            end
         endcase
      end
      // register writes win over the mode update
      if (wr_lo) begin
         nxt_ptr[7:0] = wr_data; // see RULE_13
      end
      if (wr_hi) begin
         nxt_ptr[15:8] = wr_data; // see RULE_13
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ptr_ff <= sp_pkg::WORD_ZERO;
      end else if (ce) begin
         ptr_ff <= nxt_ptr;
      end
   end
endmodule // sp_ptr_pair

//--- verification/sp_regs_checker.sv
// checker: stack pointer and indirect pointer assertions
module sp_regs_checker (
   input wire logic                 clock,
   input wire logic                 arst_n,
   input wire logic                 ce,
   input wire sp_pkg::sp_op_type    stack_op,
   input wire logic                 sp_lo_wr,
   input wire logic                 sp_hi_wr,
   input wire logic [7:0]           sp_wr_data,
   input wire logic                 gpr_wr,
   input wire logic [4:0]           gpr_wr_idx,
   input wire logic [7:0]           gpr_wr_data,
   input wire logic [2:0]           ptr_use,
   input wire sp_pkg::sp_pmode_type ptr_mode,
   input wire logic [5:0]           ptr_disp,
   input wire logic [7:0]           stack_pointer_low_ff,
   input wire logic [7:0]           stack_pointer_high_ff,
   input wire logic [15:0]          stack_addr_ff,
   input wire logic [15:0]          ptr_addr_ff,
   input wire logic [15:0]          ptr_x_ff,
   input wire logic [15:0]          ptr_y_ff,
   input wire logic [15:0]          ptr_z_ff
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   wire [15:0] sp = {stack_pointer_high_ff, stack_pointer_low_ff};
   // byte writes win over ops, so only clean ops are judged
   sequence s_op(o);
      ce && stack_op == o && !sp_lo_wr && !sp_hi_wr;
   endsequence
   property p_push;
      s_op(sp_pkg::SP_OP_PUSH) |=> sp == $past(sp) - 16'h0001 && stack_addr_ff == $past(sp);
   endproperty
   a_push: assert property (p_push) else $error("push step wrong");
   property p_call;
      s_op(sp_pkg::SP_OP_CALL) |=> sp == $past(sp) - 16'h0002;
   endproperty
   a_call: assert property (p_call) else $error("call step wrong");
   property p_pop;
      s_op(sp_pkg::SP_OP_POP) |=> sp == $past(sp) + 16'h0001 && stack_addr_ff == sp;
   endproperty
   a_pop: assert property (p_pop) else $error("pop step wrong");
   property p_ret;
      s_op(sp_pkg::SP_OP_RET) |=> sp == $past(sp) + 16'h0002;
   endproperty
   a_ret: assert property (p_ret) else $error("return step wrong");
   property p_freeze;
      !ce |=> $stable(sp) && $stable(ptr_x_ff);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
   property p_lo_wr;
      ce && sp_lo_wr |=> stack_pointer_low_ff == $past(sp_wr_data);
   endproperty
   a_lo_wr: assert property (p_lo_wr) else $error("low byte write lost");
   property p_post;
      ce && ptr_use == 3'h1 && ptr_mode == sp_pkg::SP_PM_POST && !gpr_wr
         |=> ptr_x_ff == $past(ptr_x_ff) + 16'h0001 && ptr_addr_ff == $past(ptr_x_ff);
   endproperty
   a_post: assert property (p_post) else $error("post increment wrong");
   property p_zhi;
      ce && gpr_wr && gpr_wr_idx == sp_pkg::REG_Z_HI |=> ptr_z_ff[15:8] == $past(gpr_wr_data);
   endproperty
   a_zhi: assert property (p_zhi) else $error("pointer high byte wrong");
endmodule // sp_regs_checker

//--- verification/sp_regs_bench.sv
// bench: directed tests of the stack and pointer registers
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("Error at %0t got %h expected %h", $time, (a), (b)); end end
module sp_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, arst_n = 0, ce = 1, sp_lo_wr = 0, sp_hi_wr = 0, gpr_wr = 0;
   sp_pkg::sp_op_type stack_op = sp_pkg::SP_OP_NONE;
   sp_pkg::sp_pmode_type ptr_mode = sp_pkg::SP_PM_DISP;
   logic [7:0] sp_wr_data = 8'h00, gpr_wr_data = 8'h00, stack_pointer_low_ff, stack_pointer_high_ff;
   logic [4:0] gpr_wr_idx = 5'h00;
   logic [2:0] ptr_use = 3'h0;
   logic [5:0] ptr_disp = 6'h00;
   logic [15:0] stack_addr_ff, ptr_addr_ff, ptr_x_ff, ptr_y_ff, ptr_z_ff, e;
   int n_fail = 0, total_checks = 0;
   sp_pkg::sp_op_type ops [4] = '{sp_pkg::SP_OP_PUSH, sp_pkg::SP_OP_CALL, sp_pkg::SP_OP_POP, sp_pkg::SP_OP_RET};
   logic [15:0] dl [4] = '{16'hffff, 16'hfffe, 16'h0001, 16'h0002};
   logic [15:0] ad [4] = '{16'h0000, 16'h0000, 16'h0001, 16'h0001};
   sp_regs sp_regs_i (.*);
   always #20 clock = ~clock;
   // ---------------------------------------------
   // bus cycle tasks
   // ---------------------------------------------
   task idle;
      @(posedge clock);
      stack_op <= sp_pkg::SP_OP_NONE;
      {sp_lo_wr, sp_hi_wr, gpr_wr, ptr_use} <= 6'h00;
      #1;
   endtask
   task sop(input sp_pkg::sp_op_type o);
      @(posedge clock);
      stack_op <= o;
      idle();
   endtask
   task spw(input logic [15:0] v);
      @(posedge clock);
      sp_hi_wr <= 1'b1;
      sp_wr_data <= v[15:8];
      idle();
      @(posedge clock);
      sp_lo_wr <= 1'b1;
      sp_wr_data <= v[7:0];
      idle();
   endtask
   task gw(input logic [4:0] i, input logic [7:0] d);
      @(posedge clock);
      {gpr_wr, gpr_wr_idx, gpr_wr_data} <= {1'b1, i, d};
      idle();
   endtask
   task pu(input logic [2:0] u, input sp_pkg::sp_pmode_type m, input logic [5:0] d);
      @(posedge clock);
      ptr_use <= u;
      ptr_mode <= m;
      ptr_disp <= d;
      idle();
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      conclude();
   end
   initial begin
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      #1;
      e = sp_pkg::SRAM_TOP;
      `CHK({stack_pointer_high_ff, stack_pointer_low_ff}, e)
      `CHK(ptr_x_ff, 16'h0000)
      for (int k = 0; k < 4; k++) begin
         sop(ops[k]);
         `CHK({stack_pointer_high_ff, stack_pointer_low_ff}, e + dl[k])
         `CHK(stack_addr_ff, e + ad[k])
         e = e + dl[k];
      end
      $display("test stack ops done");
      spw(16'h0300);
      sop(sp_pkg::SP_OP_PUSH);
      `CHK({stack_pointer_high_ff, stack_pointer_low_ff}, 16'h02ff)
      `CHK(stack_addr_ff, 16'h0300)
      sop(sp_pkg::sp_op_type'(5'h03));
      `CHK({stack_pointer_high_ff, stack_pointer_low_ff}, 16'h02ff)
      @(posedge clock);
      ce <= 1'b0;
      stack_op <= sp_pkg::SP_OP_CALL;
      idle();
      `CHK({stack_pointer_high_ff, stack_pointer_low_ff}, 16'h02ff)
      @(posedge clock);
      ce <= 1'b1;
      #1;
      `CHK(stack_addr_ff, 16'h02ff)
      $display("test byte writes done");
      gw(sp_pkg::REG_X_LO, 8'h00);
      gw(sp_pkg::REG_X_HI, 8'h01);
      gw(sp_pkg::REG_Y_HI, 8'h02);
      gw(sp_pkg::REG_Z_LO, 8'h10);
      gw(sp_pkg::REG_Z_HI, 8'h03);
      `CHK(ptr_x_ff, 16'h0100)
      `CHK({ptr_y_ff, ptr_z_ff}, 32'h02000310)
      pu(3'h1, sp_pkg::SP_PM_POST, 6'h00);
      `CHK({ptr_x_ff, ptr_addr_ff}, 32'h01010100)
      pu(3'h2, sp_pkg::SP_PM_PRE, 6'h00);
      `CHK({ptr_y_ff, ptr_addr_ff}, 32'h01ff01ff)
      pu(3'h4, sp_pkg::SP_PM_DISP, 6'h3f);
      `CHK({ptr_z_ff, ptr_addr_ff}, 32'h0310034f)
      $display("test pointers done");
      @(posedge clock);
      arst_n <= 1'b0;
      @(posedge clock);
      arst_n <= 1'b1;
      #1;
      `CHK({stack_pointer_high_ff, stack_pointer_low_ff}, sp_pkg::SRAM_TOP)
      `CHK({ptr_x_ff, ptr_addr_ff}, 32'h00000000)
      $display("test reset reload done");
      conclude();
   end
endmodule // sp_regs_bench
bind sp_regs sp_regs_checker sp_regs_checker_i (.*);
